// >>> ueirq_params.svh
// Purpose: Constants for the endpoint request flag block
// Assumes: Included by the design module only
// Notes: Subaddress values select the flag registers
`ifndef UEIRQ_PARAMS_SVH
`define UEIRQ_PARAMS_SVH
`define UEIRQ_SA_IN_FLAGS 8'h29
`define UEIRQ_SA_OUT_FLAGS 8'h2A
`define UEIRQ_FLAGS_RESET 4'h0
`define UEIRQ_RSVD_READ 4'h0
`define UEIRQ_CODE_FIRST_EP 5'h06
`define UEIRQ_CODE_NONE 5'h00
`define UEIRQ_NUM_EP 4
`define UEIRQ_CODE_STEP 2
`define UEIRQ_CLR_NONE 4'h0
`define UEIRQ_RDATA_NONE 8'h00
`endif

// >>> ueirq_pkg.sv
// Purpose: Types shared by the endpoint request flag block
// Assumes: Four IN and four OUT endpoints
// Notes: Event and register access groups travel as structs
package ueirq_pkg;
	typedef struct packed {
		logic [3:0] in_ack;
		logic [3:0] out_ok;
	} ueirq_events_t;
	typedef struct packed {
		logic [7:0] sub_register_select;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ueirq_access_t;
endpackage : ueirq_pkg

// >>> ueirq_flags.sv
// Purpose: Per-endpoint IN/OUT interrupt request flags with W1C clear
// Assumes: Events are one-cycle pulses synchronous to i_ref_clk
// Notes: Registers reached through a subaddress/subdata pair
`timescale 1ns/1ps
`include "ueirq_params.svh"

module ueirq_flags #(
	parameter int NUM_EP = `UEIRQ_NUM_EP
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire ueirq_pkg::ueirq_events_t i_events,
	input wire ueirq_pkg::ueirq_access_t i_access,
	output logic [7:0] o_rdata,
	output logic [3:0] o_in_ep_request,
	output logic [3:0] o_out_ep_request,
	output logic [4:0] o_irq_source_code,
	output logic o_irq_pending
);


	// Flag state and registered read and report outputs
	logic [3:0] in_ep_request;
	logic [3:0] out_ep_request;
	logic [7:0] rdata;
	logic [4:0] code;
	logic pending;

	// Next values of the registered state
	logic [3:0] next_in;
	logic [3:0] next_out;
	logic [7:0] next_rdata;
	logic [4:0] next_code;
	logic next_pending;

	// Decoded access strobes, a write and a read per request register
	logic in_wr_hit;
	logic out_wr_hit;
	logic in_rd_hit;
	logic out_rd_hit;

	// Clear masks taken from the low nibble of write data
	logic [3:0] in_clr;
	logic [3:0] out_clr;

	// Updated flags from the per-endpoint slices
	logic [3:0] in_upd;
	logic [3:0] out_upd;

	// Register select decode, shared by read and write paths
	function automatic logic sel(
		input logic [7:0] sa,
		input logic [7:0] want
	);
		sel = (sa == want);
	endfunction : sel

	// Source code of one endpoint; OUT sits one code above its IN
	function automatic logic [4:0] ep_code(
		input int ep,
		input logic is_out
	);
		ep_code = 5'(`UEIRQ_CODE_FIRST_EP + `UEIRQ_CODE_STEP * ep
			+ int'(is_out));
	endfunction : ep_code

	// subaddress decode
	// Any other subaddress raises no strobe; a read of it returns zero
	always_comb
	begin
		in_wr_hit = i_access.wr
			&& sel(i_access.sub_register_select, `UEIRQ_SA_IN_FLAGS);
		out_wr_hit = i_access.wr
			&& sel(i_access.sub_register_select, `UEIRQ_SA_OUT_FLAGS);
		in_rd_hit = i_access.rd
			&& sel(i_access.sub_register_select, `UEIRQ_SA_IN_FLAGS);
		out_rd_hit = i_access.rd
			&& sel(i_access.sub_register_select, `UEIRQ_SA_OUT_FLAGS);
	end

	// write-one clear
	// Only bits 3..0 can clear; upper write bits have no storage
	always_comb
	begin
		in_clr = `UEIRQ_CLR_NONE;
		out_clr = `UEIRQ_CLR_NONE;
		if (in_wr_hit)
		begin
			in_clr = i_access.wdata[3:0];
		end
		if (out_wr_hit)
		begin
			out_clr = i_access.wdata[3:0];
		end
	end

	// One slice per endpoint: bit ep of each register is endpoint ep
	genvar ep;
	generate
		for (ep = 0; ep < NUM_EP; ep = ep + 1)
		begin : g_ep
			// set beats clear, OR-ed last so no event is lost
			assign in_upd[ep] = (in_ep_request[ep] & ~in_clr[ep])
				| i_events.in_ack[ep];
			assign out_upd[ep] = (out_ep_request[ep] & ~out_clr[ep])
				| i_events.out_ok[ep];
		end
	endgenerate

	// Flag next values; reset is applied in the register process
	always_comb
	begin
		next_in = in_upd;
		next_out = out_upd;
	end

	// Read data; a read returns the flags before a same-cycle write
	// Unmapped subaddresses read as zero rather than holding old data
	always_comb
	begin
		next_rdata = rdata;
		if (i_access.rd)
		begin
			next_rdata = `UEIRQ_RDATA_NONE;
			if (in_rd_hit)
			begin
				next_rdata = {`UEIRQ_RSVD_READ, in_ep_request};
			end
			if (out_rd_hit)
			begin
				next_rdata = {`UEIRQ_RSVD_READ, out_ep_request};
			end
		end
	end

	// priority encoder, search high to low so lowest wins
	// Built from registered flags, trading one cycle of lag for timing
	always_comb
	begin
		next_code = `UEIRQ_CODE_NONE;
		next_pending = 1'b0;
		for (int i = NUM_EP - 1; i >= 0; i--)
		begin
			if (out_ep_request[i])
			begin
				next_code = ep_code(i, 1'b1);
				next_pending = 1'b1;
			end
			if (in_ep_request[i])
			begin
				next_code = ep_code(i, 1'b0);
				next_pending = 1'b1;
			end
		end
	end

	// Flag registers, all clear on reset
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			in_ep_request <= `UEIRQ_FLAGS_RESET;
			out_ep_request <= `UEIRQ_FLAGS_RESET;
		end
		else
		begin
			in_ep_request <= next_in;
			out_ep_request <= next_out;
		end
	end

	// Read data register, holds until the next read strobe
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			rdata <= `UEIRQ_RDATA_NONE;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	// Source report registers, code 00 qualified by pending
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			code <= `UEIRQ_CODE_NONE;
			pending <= 1'b0;
		end
		else
		begin
			code <= next_code;
			pending <= next_pending;
		end
	end

	// Outputs straight from flip-flops; code lags flags by one cycle
	assign o_in_ep_request = in_ep_request;
	assign o_out_ep_request = out_ep_request;
	assign o_rdata = rdata;
	assign o_irq_source_code = code;
	assign o_irq_pending = pending;

endmodule : ueirq_flags

// >>> ueirq_host.sv
// Purpose: host side events. Assumes: one clock. Notes: never faulty
`timescale 1ns/1ps
module ueirq_host (input wire logic [7:0] i_req,
	output ueirq_pkg::ueirq_events_t o_events);
	assign o_events = i_req;
endmodule : ueirq_host

// >>> ueirq_flags_props.sv
// Purpose: flag checks. Assumes: one clock. Notes: bind at foot
`timescale 1ns/1ps
module ueirq_chk (input wire logic i_ref_clk, i_rstn, o_irq_pending,
	input wire ueirq_pkg::ueirq_events_t i_events,
	input wire ueirq_pkg::ueirq_access_t i_access,
	input wire logic [7:0] o_rdata,
	input wire logic [4:0] o_irq_source_code,
	input wire logic [3:0] o_in_ep_request, o_out_ep_request);
	// Short views; only the low nibble of write data matters
	wire [3:0] fi = o_in_ep_request, fo = o_out_ep_request;
	wire [3:0] ia = i_events.in_ack, oa = i_events.out_ok;
	wire [3:0] wd = i_access.wdata[3:0];
	wire [7:0] sa = i_access.sub_register_select;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	in_set_a: assert property (|ia |=> (fi & $past(ia)) == $past(ia))
		else $error("in flag not set");
	set_wins_a: assert property (i_access.wr && sa == 8'h29
		&& |(ia & wd) |=> (fi & $past(ia & wd)) == $past(ia & wd))
		else $error("set lost to clear");
	code_first_a: assert property (fi[0] |=>
		o_irq_source_code == 5'h06) else $error("in0 code wrong");
	out_set_a: assert property (|oa |=> (fo & $past(oa)) == $past(oa))
		else $error("out flag not set");
	in_clr_a: assert property (i_access.wr && sa == 8'h29 && ia == 4'h0
		|=> fi == ($past(fi) & ~$past(wd))) else $error("in clear wrong");
	out_keep_a: assert property (!(i_access.wr && sa == 8'h2A)
		&& oa == 4'h0 |=> fo == $past(fo)) else $error("out flag moved");
	in_read_a: assert property (i_access.rd && sa == 8'h29 |=>
		o_rdata == {4'h0, $past(fi)}) else $error("in read wrong");
	out_read_a: assert property (i_access.rd && sa == 8'h2A |=>
		o_rdata == {4'h0, $past(fo)}) else $error("out read wrong");
	rsvd_zero_a: assert property (o_rdata[7:4] == 4'h0)
		else $error("upper read bits set");
	pend_code_a: assert property (|{fi, fo} |=> o_irq_pending &&
		o_irq_source_code != 5'h00) else $error("request not shown");
endmodule : ueirq_chk
bind ueirq_flags ueirq_chk chk_i (.*);

// >>> ueirq_flags_test.sv
// Purpose: bench. Assumes: 200 MHz clock. Notes: fixed latencies
`timescale 1ns/1ps
module ueirq_flags_test;
	logic i_ref_clk = 1'b0, i_rstn = 1'b0, o_irq_pending;
	logic [7:0] req = 8'h00, o_rdata;
	logic [3:0] o_in_ep_request, o_out_ep_request;
	logic [4:0] o_irq_source_code;
	ueirq_pkg::ueirq_events_t i_events;
	ueirq_pkg::ueirq_access_t i_access = '0;
	int err_total = 0, cmp_count = 0;
	// Clock, host model, block and packed views of its outputs
	always #2.5 i_ref_clk = ~i_ref_clk;
	ueirq_host host (.i_req(req), .o_events(i_events));
	ueirq_flags uut (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_events(i_events),
		.i_access(i_access),
		.o_rdata(o_rdata),
		.o_in_ep_request(o_in_ep_request),
		.o_out_ep_request(o_out_ep_request),
		.o_irq_source_code(o_irq_source_code),
		.o_irq_pending(o_irq_pending)
	);
	wire [15:0] seen = {o_rdata, o_in_ep_request, o_out_ep_request};
	wire [7:0] src = {2'h0, o_irq_pending, o_irq_source_code};
	task automatic acc(input logic [17:0] a, input logic [7:0] e);
		@(posedge i_ref_clk) {i_access, req} <= {a, e};
		@(posedge i_ref_clk) {i_access, req} <= 26'h0;
		#1;
	endtask : acc
	task automatic chk(input logic [15:0] g, x);
		cmp_count++;
		err_total += int'(g !== x);
		if (g !== x) $display("ERROR %0t got %h want %h", $time, g, x);
	endtask : chk
	task automatic t_flags;
		acc(18'h0, 8'h29);
		chk(seen, 16'h0029);
		acc({8'h29, 10'h100}, 8'h00);
		chk(seen, 16'h0229);
		acc({8'h2A, 10'h205}, 8'h04); // upper bits written 0
		chk({seen[7:0], src}, 16'h2C27);
		acc({8'h2A, 10'h100}, 8'h00);
		chk(seen, 16'h0C2C);
		acc({8'h2B, 10'h30F}, 8'h00); // upper bits written 0
		chk({seen[15:8], src}, 16'h0028);
		acc({8'h29, 10'h20F}, 8'h00);
		acc({8'h2A, 10'h30F}, 8'h00);
		chk(seen, 16'h0C00);
		$display("t_flags done");
	endtask : t_flags
	// Priority codes of endpoint 3 and the idle code after clearing
	task automatic t_code;
		acc(18'h0, 8'h88);
		acc(18'h0, 8'h00);
		chk({seen[7:0], src}, 16'h882C);
		acc({8'h29, 10'h208}, 8'h00);
		acc(18'h0, 8'h00);
		chk({seen[7:0], src}, 16'h082D);
		acc({8'h2A, 10'h208}, 8'h00);
		acc(18'h0, 8'h00);
		chk({seen[7:0], src}, 16'h0000);
		$display("t_code done");
	endtask : t_code
	task automatic give_verdict;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// Reset for 20 cycles so every flag starts clear
	initial
	begin
		repeat (20) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		t_flags();
		t_code();
		give_verdict();
	end
endmodule : ueirq_flags_test
